// ### core_ops.sv
// Executor for subroutine calls, timer kick, invert, erase and minus-one operations.
// Assumes an APB master on clk_i; instructions are issued by writing the instruction register.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module core_ops #(
    parameter int STACK_DEPTH = 16,
    parameter int PRESCALE_W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int PC_W = core_ops_pkg::PC_W;
    localparam int DW = core_ops_pkg::DATA_W;

    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH || SP_W > 15) begin : g_chk_depth
        $error("STACK_DEPTH must be a power of two from 2 to 32768");
    end
    if (PRESCALE_W < 1 || PRESCALE_W > 16) begin : g_chk_pre
        $error("PRESCALE_W must be 1 to 16");
    end

    logic [DW-1:0] acc_q, acc_d;
    logic [core_ops_pkg::LATCH_W-1:0] latch_q, latch_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic zero_q, zero_d;
    logic expiry_n_q, expiry_n_d;
    logic sleep_n_q, sleep_n_d;
    logic [DW-1:0] wdt_q, wdt_d;
    logic [PRESCALE_W-1:0] pre_q, pre_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic [core_ops_pkg::FILE_W-1:0] faddr_q, faddr_d;
    core_ops_pkg::state_t state_q, state_d;
    logic [31:0] prdata_q, prdata_d;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [DW-1:0] file_mem [1 << core_ops_pkg::FILE_W];

    logic busy, access, instr_hit, issue, wr;
    core_ops_pkg::op_t op;
    logic [core_ops_pkg::LIT_W-1:0] lit;
    logic [core_ops_pkg::FILE_W-1:0] fsel;
    logic dest_file;
    logic [DW-1:0] fval, result;
    logic push_en, fwe;
    logic [PC_W-1:0] pc_next, stack_head;
    logic [core_ops_pkg::FILE_W-1:0] fwa;
    logic [DW-1:0] fwd;
    logic mapped;

    assign busy = (state_q == core_ops_pkg::ST_SECOND);
    assign access = psel_i & penable_i;
    assign instr_hit = (paddr_i == core_ops_pkg::OFS_INSTR);
    // Stall only a new instruction while a two-cycle one finishes
    assign pready_o = ~(busy & pwrite_i & instr_hit);
    assign wr = access & pwrite_i & pready_o;
    assign issue = wr & instr_hit;
    assign op = core_ops_pkg::op_t'(pwdata_i[core_ops_pkg::OP_LSB +: 4]);
    assign lit = pwdata_i[core_ops_pkg::LIT_W-1:0];
    assign fsel = pwdata_i[core_ops_pkg::FILE_W-1:0];
    assign dest_file = pwdata_i[core_ops_pkg::DEST_BIT];
    assign fval = file_mem[fsel];
    assign pc_next = pc_q + 15'h0001;
    assign stack_head = stack_mem[sp_q - 1'b1];
    assign prdata_o = prdata_q;

    always_comb begin
        case (paddr_i)
            core_ops_pkg::OFS_INSTR, core_ops_pkg::OFS_ACC, core_ops_pkg::OFS_LATCH,
            core_ops_pkg::OFS_PC, core_ops_pkg::OFS_STACK, core_ops_pkg::OFS_STATUS,
            core_ops_pkg::OFS_FADDR, core_ops_pkg::OFS_FDATA, core_ops_pkg::OFS_GUARD: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        pslverr_o = access & ~mapped;
    end

    // Register read data captured in the setup phase
    always_comb begin
        prdata_d = prdata_q;
        if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_d = 32'h0000_0000;
            case (paddr_i)
                core_ops_pkg::OFS_INSTR: prdata_d[core_ops_pkg::ST_BUSY] = busy;
                core_ops_pkg::OFS_ACC: prdata_d[DW-1:0] = acc_q;
                core_ops_pkg::OFS_LATCH: prdata_d[core_ops_pkg::LATCH_W-1:0] = latch_q;
                core_ops_pkg::OFS_PC: prdata_d[PC_W-1:0] = pc_q;
                core_ops_pkg::OFS_STACK: begin
                    prdata_d[PC_W-1:0] = stack_head;
                    prdata_d[core_ops_pkg::STACK_PTR_LSB +: SP_W] = sp_q;
                end
                core_ops_pkg::OFS_STATUS: begin
                    prdata_d[core_ops_pkg::ST_ZERO] = zero_q;
                    prdata_d[core_ops_pkg::ST_EXPIRY] = expiry_n_q;
                    prdata_d[core_ops_pkg::ST_SLEEP] = sleep_n_q;
                    prdata_d[core_ops_pkg::ST_BUSY] = busy;
                end
                core_ops_pkg::OFS_FADDR: prdata_d[core_ops_pkg::FILE_W-1:0] = faddr_q;
                core_ops_pkg::OFS_FDATA: prdata_d[DW-1:0] = file_mem[faddr_q];
                core_ops_pkg::OFS_GUARD: begin
                    prdata_d[DW-1:0] = wdt_q;
                    prdata_d[core_ops_pkg::GUARD_PRE_LSB +: PRESCALE_W] = pre_q;
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Instruction execution and software register writes
    always_comb begin
        acc_d = acc_q;
        latch_d = latch_q;
        pc_d = pc_q;
        zero_d = zero_q;
        sp_d = sp_q;
        faddr_d = faddr_q;
        state_d = core_ops_pkg::ST_IDLE;
        push_en = 1'b0;
        fwe = 1'b0;
        fwa = faddr_q;
        fwd = pwdata_i[DW-1:0];
        result = ~fval;
        if (issue) begin
            case (op)
                core_ops_pkg::OP_CALL_LIT: begin
                    push_en = 1'b1;
                    pc_d = {latch_q[6:3], lit};
                    state_d = core_ops_pkg::ST_SECOND;
                end
                core_ops_pkg::OP_CALL_ACC: begin
                    push_en = 1'b1;
                    pc_d = {latch_q, acc_q};
                    state_d = core_ops_pkg::ST_SECOND;
                end
                core_ops_pkg::OP_KICK: begin
                    pc_d = pc_next;
                end
                core_ops_pkg::OP_INVERT, core_ops_pkg::OP_MINUS: begin
                    result = (op == core_ops_pkg::OP_INVERT) ? ~fval : fval - 8'h01;
                    zero_d = (result == core_ops_pkg::CLEARED);
                    if (dest_file) begin
                        fwe = 1'b1;
                        fwa = fsel;
                        fwd = result;
                    end else begin
                        acc_d = result;
                    end
                    pc_d = pc_next;
                end
                core_ops_pkg::OP_ERASE_FILE: begin
                    fwe = 1'b1;
                    fwa = fsel;
                    fwd = core_ops_pkg::CLEARED;
                    zero_d = 1'b1;
                    pc_d = pc_next;
                end
                core_ops_pkg::OP_ERASE_ACC: begin
                    acc_d = core_ops_pkg::CLEARED;
                    zero_d = 1'b1;
                    pc_d = pc_next;
                end
                default: begin
                end
            endcase
        end else if (wr) begin
            case (paddr_i)
                core_ops_pkg::OFS_ACC: acc_d = pwdata_i[DW-1:0];
                core_ops_pkg::OFS_LATCH: latch_d = pwdata_i[core_ops_pkg::LATCH_W-1:0];
                core_ops_pkg::OFS_PC: pc_d = pwdata_i[PC_W-1:0];
                core_ops_pkg::OFS_STATUS: zero_d = pwdata_i[core_ops_pkg::ST_ZERO];
                core_ops_pkg::OFS_FADDR: faddr_d = pwdata_i[core_ops_pkg::FILE_W-1:0];
                core_ops_pkg::OFS_FDATA: fwe = 1'b1;
                default: begin
                end
            endcase
        end
        if (push_en) begin
            sp_d = sp_q + 1'b1;
        end
    end

    // Guard timer: prescaler ticks the count; count wrap drops the expiry flag
    always_comb begin
        pre_d = pre_q + 1'b1;
        wdt_d = wdt_q;
        expiry_n_d = expiry_n_q;
        sleep_n_d = sleep_n_q;
        if (&pre_q) begin
            wdt_d = wdt_q + 8'h01;
            if (&wdt_q) begin
                expiry_n_d = 1'b0;
            end
        end
        if (issue && op == core_ops_pkg::OP_KICK) begin
            wdt_d = core_ops_pkg::CLEARED;
            pre_d = '0;
            expiry_n_d = 1'b1;
            sleep_n_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_q <= core_ops_pkg::CLEARED;
            latch_q <= '0;
            pc_q <= core_ops_pkg::PC_RST;
            zero_q <= 1'b0;
            expiry_n_q <= 1'b1;
            sleep_n_q <= 1'b1;
            wdt_q <= core_ops_pkg::CLEARED;
            pre_q <= '0;
            sp_q <= '0;
            faddr_q <= '0;
            state_q <= core_ops_pkg::ST_IDLE;
            prdata_q <= 32'h0000_0000;
        end else begin
            acc_q <= acc_d;
            latch_q <= latch_d;
            pc_q <= pc_d;
            zero_q <= zero_d;
            expiry_n_q <= expiry_n_d;
            sleep_n_q <= sleep_n_d;
            wdt_q <= wdt_d;
            pre_q <= pre_d;
            sp_q <= sp_d;
            faddr_q <= faddr_d;
            state_q <= state_d;
            prdata_q <= prdata_d;
        end
    end

    // Storage arrays carry no reset
    always_ff @(posedge clk_i) begin
        if (push_en) begin
            stack_mem[sp_q] <= pc_next;
        end
        if (fwe) begin
            file_mem[fwa] <= fwd;
        end
    end

    logic is_call;
    assign is_call = issue && (op == core_ops_pkg::OP_CALL_LIT || op == core_ops_pkg::OP_CALL_ACC);

    chk_lit_low: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_CALL_LIT |=> pc_q[10:0] == $past(lit))
        else $error("literal call low bits wrong");
    chk_lit_high: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_CALL_LIT |=> pc_q[14:11] == $past(latch_q[6:3]))
        else $error("literal call high bits wrong");
    chk_lit_push: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_CALL_LIT |=> stack_head == $past(pc_q) + 15'h0001
        && busy ##1 !busy)
        else $error("literal call push or length wrong");
    chk_kick_flags: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_KICK |=> wdt_q == 8'h00 && expiry_n_q && sleep_n_q)
        else $error("kick did not clear timer and flags");
    chk_kick_prescale: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_KICK |=> pre_q == '0 ##1 pre_q == 1)
        else $error("kick did not clear prescaler");
    chk_acc_target: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_CALL_ACC |=> pc_q == {$past(latch_q), $past(acc_q)})
        else $error("accumulator call target wrong");
    chk_acc_push: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_CALL_ACC |=> stack_head == $past(pc_q) + 15'h0001
        && sp_q == $past(sp_q) + 1'b1 ##1 !busy)
        else $error("accumulator call push or length wrong");
    chk_invert_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_INVERT && !dest_file |=> acc_q == ~$past(fval))
        else $error("invert result wrong");
    chk_invert_file: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_INVERT && dest_file
        |=> file_mem[$past(fsel)] == ~$past(fval) && acc_q == $past(acc_q))
        else $error("invert destination wrong");
    chk_erase_file: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_ERASE_FILE |=> file_mem[$past(fsel)] == 8'h00 && zero_q)
        else $error("erase file wrong");
    chk_minus_dest: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_MINUS && !dest_file |=> acc_q == $past(fval) - 8'h01)
        else $error("minus one result wrong");
    chk_minus_file: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_MINUS && dest_file
        |=> file_mem[$past(fsel)] == $past(fval) - 8'h01 && acc_q == $past(acc_q))
        else $error("minus one file destination wrong");
    chk_minus_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_MINUS |=> zero_q == ($past(fval) == 8'h01))
        else $error("minus one zero flag wrong");
    chk_invert_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_INVERT |=> zero_q == ($past(fval) == 8'hFF))
        else $error("invert zero flag wrong");
    chk_erase_acc: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op == core_ops_pkg::OP_ERASE_ACC |=> acc_q == 8'h00 && zero_q)
        else $error("erase accumulator wrong");
    chk_zero_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        is_call |=> zero_q == $past(zero_q) && expiry_n_q == $past(expiry_n_q))
        else $error("call changed a flag");
    chk_single_pc: assert property (@(posedge clk_i) disable iff (reset_i)
        issue && op inside {core_ops_pkg::OP_KICK, core_ops_pkg::OP_INVERT,
        core_ops_pkg::OP_MINUS, core_ops_pkg::OP_ERASE_FILE, core_ops_pkg::OP_ERASE_ACC}
        |=> pc_q == $past(pc_q) + 15'h0001 && !busy)
        else $error("single-cycle op did not advance counter");
endmodule

// ### core_ops_pkg.sv
// Constants, register map and types for the call, clear and decrement executor.
// Assumes an APB master with 32-bit data drives the register slave.
//
// Overview of operation
// - A literal call loads its 11-bit operand into counter bits 10 to 0.
// - A literal call fills counter bits 14 to 11 from latch bits 6 to 3.
// - A literal call first pushes counter plus one on the stack and takes two cycles.
// - A timer kick zeroes the timer count and sets both low-active flags to one.
// - A timer kick also zeroes the timer prescaler.
// - An accumulator call loads the accumulator into counter bits 7 to 0 and latch 6 to 0 above.
// - An accumulator call first pushes counter plus one on the stack and takes two cycles.
// - Invert complements the addressed file register and updates the zero flag.
// - Invert writes the accumulator when the destination bit is 0, the file register when 1.
// - Erase file writes zero into the addressed file register and sets the zero flag.
// - Minus one decrements the file register into the chosen destination and updates zero.
// - Erase accumulator writes zero into the accumulator and sets the zero flag.
package core_ops_pkg;
    localparam int PC_W = 15;
    localparam int DATA_W = 8;
    localparam int LATCH_W = 7;
    localparam int FILE_W = 7;
    localparam int LIT_W = 11;
    // Byte offsets
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_LATCH = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0C;
    localparam logic [7:0] OFS_STACK = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_FADDR = 8'h18;
    localparam logic [7:0] OFS_FDATA = 8'h1C;
    localparam logic [7:0] OFS_GUARD = 8'h20;
    // Instruction word fields
    localparam int OP_LSB = 16;
    localparam int DEST_BIT = 12;
    // Status bits
    localparam int ST_ZERO = 0;
    localparam int ST_EXPIRY = 1;
    localparam int ST_SLEEP = 2;
    localparam int ST_BUSY = 3;
    // Other field positions
    localparam int STACK_PTR_LSB = 16;
    localparam int GUARD_PRE_LSB = 8;
    // Reset values
    localparam logic [DATA_W-1:0] CLEARED = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CALL_LIT = 4'h1,
        OP_CALL_ACC = 4'h2,
        OP_KICK = 4'h3,
        OP_INVERT = 4'h4,
        OP_ERASE_FILE = 4'h5,
        OP_MINUS = 4'h6,
        OP_ERASE_ACC = 4'h7
    } op_t;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SECOND = 1'b1
    } state_t;
endpackage

// ### core_ops_tb.sv
// Self-checking bench for the call, clear and minus-one executor.
// Assumes the executor's APB slave on clk_i and a synchronous active-high reset.
`timescale 1ns/1ps
module core_ops_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] paddr_i = 8'h00;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    int errors = 0;
    int checks = 0;
    logic [31:0] v;
    logic err;

    core_ops #(.STACK_DEPTH(16), .PRESCALE_W(2)) dut_u (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .paddr_i(paddr_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o)
    );

    always #5 clk_i = ~clk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves the bus selected for the next setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic e);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        rd = 32'h0000_0000;
        e = 1'b0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        while (!done && n < 20) begin
            // Answer sampled mid-cycle, as it stands at the next rising edge
            @(negedge clk_i);
            if (pready_o === 1'b1) begin
                done = 1'b1;
                rd = prdata_o;
                e = pslverr_o;
            end
            n++;
            @(posedge clk_i);
        end
        if (!done) begin
            errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, v, err);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, v, err);
        check(v & m, e);
    endtask

    task automatic idle();
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    function automatic logic [31:0] ins(input logic [3:0] op, input logic dst,
                                       input logic [10:0] k);
        return {12'h000, op, 3'b000, dst, 1'b0, k};
    endfunction

    // Presets file, accumulator, zero flag and counter, runs one operation, checks all
    task automatic run(input logic [3:0] op, input logic dst, input logic [6:0] fa,
                       input logic [7:0] fd, input logic [7:0] w, input logic z,
                       input logic [7:0] ew, input logic [7:0] ef, input logic ez,
                       input logic [14:0] epc);
        wr(core_ops_pkg::OFS_FADDR, {25'h0, fa});
        wr(core_ops_pkg::OFS_FDATA, {24'h0, fd});
        wr(core_ops_pkg::OFS_ACC, {24'h0, w});
        wr(core_ops_pkg::OFS_STATUS, {31'h0, z});
        wr(core_ops_pkg::OFS_PC, 32'h0000_0100);
        wr(core_ops_pkg::OFS_INSTR, ins(op, dst, {4'h0, fa}));
        rdc(core_ops_pkg::OFS_ACC, 32'hFF, {24'h0, ew});
        rdc(core_ops_pkg::OFS_FDATA, 32'hFF, {24'h0, ef});
        rdc(core_ops_pkg::OFS_STATUS, 32'h1, {31'h0, ez});
        rdc(core_ops_pkg::OFS_PC, 32'h7FFF, {17'h0, epc});
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rdc(core_ops_pkg::OFS_STATUS, 32'h7, 32'h6);
        rdc(core_ops_pkg::OFS_PC, 32'h7FFF, 32'h0);
        // A literal call, then two accumulator calls back to back
        wr(core_ops_pkg::OFS_ACC, 32'h0000_00C3);
        wr(core_ops_pkg::OFS_LATCH, 32'h0000_0055);
        wr(core_ops_pkg::OFS_PC, 32'h0000_1234);
        wr(core_ops_pkg::OFS_STATUS, 32'h0000_0001);
        wr(core_ops_pkg::OFS_INSTR, ins(core_ops_pkg::OP_CALL_LIT, 1'b0, 11'h5A5));
        rdc(core_ops_pkg::OFS_PC, 32'h7FFF, 32'h55A5);
        rdc(core_ops_pkg::OFS_STACK, 32'h7FFF, 32'h1235);
        wr(core_ops_pkg::OFS_INSTR, ins(core_ops_pkg::OP_CALL_ACC, 1'b0, 11'h000));
        wr(core_ops_pkg::OFS_INSTR, ins(core_ops_pkg::OP_CALL_ACC, 1'b0, 11'h000));
        rdc(core_ops_pkg::OFS_PC, 32'h7FFF, 32'h55C3);
        rdc(core_ops_pkg::OFS_STACK, 32'h000F_7FFF, 32'h0003_55C4);
        rdc(core_ops_pkg::OFS_STATUS, 32'h7, 32'h7);
        // Single-cycle operations at the top file address and at count boundaries, then an unused code that changes nothing
        run(4'h4, 1'b0, 7'h7F, 8'hFF, 8'h5A, 1'b0, 8'h00, 8'hFF, 1'b1, 15'h101);
        run(4'h4, 1'b1, 7'h7F, 8'h0F, 8'h5A, 1'b1, 8'h5A, 8'hF0, 1'b0, 15'h101);
        run(4'h5, 1'b0, 7'h05, 8'h33, 8'h5A, 1'b0, 8'h5A, 8'h00, 1'b1, 15'h101);
        run(4'h6, 1'b0, 7'h05, 8'h01, 8'h5A, 1'b0, 8'h00, 8'h01, 1'b1, 15'h101);
        run(4'h6, 1'b1, 7'h05, 8'h00, 8'h5A, 1'b1, 8'h5A, 8'hFF, 1'b0, 15'h101);
        run(4'h7, 1'b0, 7'h05, 8'h33, 8'h99, 1'b0, 8'h00, 8'h33, 1'b1, 15'h101);
        run(4'h8, 1'b0, 7'h05, 8'h33, 8'h99, 1'b0, 8'h99, 8'h33, 1'b0, 15'h100);
        // Unmapped place is refused
        apb(1'b0, 8'h24, 32'h0000_0000, v, err);
        check({31'h0, err}, 32'h1);
        check(v, 32'h0);
        idle();
        // Let the timer expire, then kick it
        repeat (1100) @(posedge clk_i);
        rdc(core_ops_pkg::OFS_STATUS, 32'h2, 32'h0);
        wr(core_ops_pkg::OFS_INSTR, ins(core_ops_pkg::OP_KICK, 1'b0, 11'h000));
        rdc(core_ops_pkg::OFS_GUARD, 32'hFF, 32'h0);
        check({31'h0, v[9:8] <= 2'h1}, 32'h1);
        rdc(core_ops_pkg::OFS_STATUS, 32'h6, 32'h6);
        idle();
        summarize();
    end
endmodule
